// File: core/ppsc_map.svh
// Constants for the PHY power-state controller: encodings and timing counts.
// Assumes inclusion by the design, checker and bench files by bare name.
`ifndef PPSC_MAP_SVH
`define PPSC_MAP_SVH
// ==========================================================
// Transmit lane drive encodings
`define PPSC_TX_UNDEF 3'h0
`define PPSC_TX_DIFF 3'h1
`define PPSC_TX_GND 3'h2
`define PPSC_TX_ACDET 3'h3
`define PPSC_TX_IDLE 3'h4
`define PPSC_TX_HIZ 3'h5
// ==========================================================
// Receiver termination encodings
`define PPSC_RX_UNDEF 3'h0
`define PPSC_RX_CTAP 3'h1
`define PPSC_RX_DIFF 3'h2
`define PPSC_RX_DCDET 3'h3
`define PPSC_RX_OFF 3'h4
// ==========================================================
// Inactive lane state codes that call for relock on width increase
`define PPSC_INLN_RELOCK_A 2'h1
`define PPSC_INLN_RELOCK_B 2'h3
// ==========================================================
// Relock request pulse length in ns, and its cycle count at 125 MHz
`define PPSC_RELOCK_NS 64
`define PPSC_CLK_MHZ 125
`define PPSC_RELOCK_CYC ((`PPSC_RELOCK_NS * `PPSC_CLK_MHZ + 999) / 1000)
`endif

// File: core/ppsc_pkg.sv
// Types for the PHY power-state controller.
// Assumes ppsc_map.svh is on the include path.
package ppsc_pkg;
    typedef enum logic [2:0] {
        PPSC_PH_UNPOWERED = 3'h0,
        PPSC_PH_PWR_LOW = 3'h1,
        PPSC_PH_COLD = 3'h2,
        PPSC_PH_AC_DETECT = 3'h3,
        PPSC_PH_WARM = 3'h4,
        PPSC_PH_ACTIVE = 3'h5,
        PPSC_PH_DISC = 3'h6,
        PPSC_PH_OFF = 3'h7
    } ppsc_phy_req_e;

    typedef enum logic [8:0] {
        PPSC_S_UNPOWERED = 9'h001,
        PPSC_S_PWR_LOW = 9'h002,
        PPSC_S_COLD = 9'h004,
        PPSC_S_AC_DETECT = 9'h008,
        PPSC_S_WARM = 9'h010,
        PPSC_S_ACTIVE = 9'h020,
        PPSC_S_DISC1 = 9'h040,
        PPSC_S_DISC2 = 9'h080,
        PPSC_S_OFF = 9'h100
    } ppsc_state_e;

    typedef struct packed {
        logic hot_plug_enable;
        logic stop_tristate_enable;
        logic [1:0] inactive_lane_state;
        logic [1:0] power_state_select;
        logic ac_supported;
        logic gen3_protocol;
        logic high_freq;
        logic link_16bit;
    } ppsc_cfg_s;

    typedef struct packed {
        logic [2:0] clk_lane;
        logic [2:0] data_lane;
        logic [2:0] rx_term;
        logic dll_on;
        logic dll_hold;
        logic pr_on;
        logic pr_hold;
        logic comp_enable;
        logic coding_8b10b;
        logic scramble;
        logic [1:0] ctl_lines;
    } ppsc_ctl_s;
endpackage

// File: core/ppsc_sync.sv
// Two-flop level synchroniser, one per bit through a generate loop.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/100ps
module ppsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // First stage feeds only the second stage
            always_ff @(posedge core_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    // Reset to the pin's idle level so no false edge follows reset
                    meta_r[i] <= RST_VAL[i];
                    sync_out[i] <= RST_VAL[i];
                end
                else
                begin
                    meta_r[i] <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// File: core/ppsc_ctrl.sv
// PHY power-state controller: lane drive, termination, DLL and relock control.
// Assumes sideband pins and the link clock arrive asynchronous to core_clk;
// configuration bits are quasi-static inputs from core_clk logic.
//
// Operation
// - Cold reset uses DC lane states; AC detect only when DC not detected
// - Off or deepest level with hot-plug: ground-terminated tx, center-tap rx
// - Off without hot-plug: tx high impedance (DC) or ground termination
// - Off without hot-plug: receiver amplifier disabled
// - First-gen disconnect: tx high impedance only if stop-tristate enabled
// - First-gen disconnect with tristate clear: keep differential drive
// - No hot-plug/AC support: no tx obligation while power-good low
// - Gen3 with hot-plug or AC: ground-terminate tx while power-good low
// - After stop release, relock on width increase with lane state 01 or 11
// - Relock after deepest level/off exit, frequency change, idle timer expiry
// - Relock leaving warm reset; optionally every stop release with hot-plug and power-state select bit 1 set
// - Undefined lane states are implementation choice
// - High-skew sideband devices must support hot-plug
// - AC coupling optional; any mode combination allowed in link test
// - Compensation logic disabled while PHY is off
// - Active-hold level keeps every lane active
`timescale 1ns/100ps
`include "ppsc_map.svh"
module ppsc_ctrl #(
    parameter logic HOT_PLUG_SUPPORTED = 1'b1,
    parameter logic RELOCK_EVERY_STOP = 1'b0,
    parameter int RELOCK_CYC = `PPSC_RELOCK_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic power_good,
    input wire logic link_stop_n,
    input wire logic link_reset_n,
    input wire logic link_clk,
    input wire ppsc_pkg::ppsc_phy_req_e phy_request,
    input wire logic dc_coupling_detected,
    input wire ppsc_pkg::ppsc_cfg_s cfg,
    input wire logic width_increase,
    input wire logic freq_change,
    input wire logic idle_timer_expired,
    output ppsc_pkg::ppsc_ctl_s lane_ctl,
    output ppsc_pkg::ppsc_state_e phy_state,
    output logic dll_relock,
    output logic link_clk_edge,
    output logic ac_mode
);
    import ppsc_pkg::*;

    // ==========================================================
    // Sideband synchronisation
    logic [3:0] sync_w;
    logic pg_s, stop_n_s, rst_n_s, lclk_s;
    // Stop rests high when released; a low reset value would fake a stop release
    ppsc_sync #(.W(4), .RST_VAL(4'h4)) ppsc_sync_i (
        .core_clk(core_clk),
        .resetn(resetn),
        .async_in({power_good, link_stop_n, link_reset_n, link_clk}),
        .sync_out(sync_w)
    );
    assign {pg_s, stop_n_s, rst_n_s, lclk_s} = sync_w;

    logic lclk_d_r;
    logic stop_n_d_r;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lclk_d_r <= 1'b0;
            stop_n_d_r <= 1'b1;
            link_clk_edge <= 1'b0;
        end
        else
        begin
            lclk_d_r <= lclk_s;
            stop_n_d_r <= stop_n_s;
            link_clk_edge <= lclk_s & ~lclk_d_r;
        end
    end
    logic stop_release;
    assign stop_release = stop_n_s & ~stop_n_d_r;

    // ==========================================================
    // PHY state machine
    ppsc_state_e state_r, state_nxt;
    always_comb
    begin
        state_nxt = state_r;
        if (!pg_s)
            state_nxt = PPSC_S_PWR_LOW;
        else
        begin
            case (state_r)
                PPSC_S_UNPOWERED, PPSC_S_PWR_LOW:
                    state_nxt = PPSC_S_COLD;
                PPSC_S_COLD:
                begin
                    // AC detect only when AC supported and DC not seen
                    if (cfg.ac_supported && !dc_coupling_detected)
                        state_nxt = PPSC_S_AC_DETECT;
                    else if (rst_n_s)
                        state_nxt = PPSC_S_WARM;
                end
                PPSC_S_AC_DETECT:
                    if (rst_n_s)
                        state_nxt = PPSC_S_WARM;
                PPSC_S_WARM:
                    if (phy_request == PPSC_PH_ACTIVE)
                        state_nxt = PPSC_S_ACTIVE;
                    else if (phy_request == PPSC_PH_OFF)
                        state_nxt = PPSC_S_OFF;
                default:
                begin
                    if (!rst_n_s)
                        state_nxt = PPSC_S_WARM;
                    else if (phy_request == PPSC_PH_OFF)
                        state_nxt = PPSC_S_OFF;
                    else if (!stop_n_s && phy_request == PPSC_PH_DISC)
                    begin
                        // Select bit 0 picks the shallower of the two saving levels
                        if (cfg.power_state_select == 2'h3)
                            state_nxt = PPSC_S_OFF;
                        else if (cfg.power_state_select == 2'h0)
                            state_nxt = PPSC_S_ACTIVE;
                        else if (cfg.power_state_select[0])
                            state_nxt = PPSC_S_DISC1;
                        else
                            state_nxt = PPSC_S_DISC2;
                    end
                    else if (stop_n_s && state_r != PPSC_S_OFF)
                        state_nxt = PPSC_S_ACTIVE;
                    else if (stop_n_s && phy_request == PPSC_PH_ACTIVE)
                        state_nxt = PPSC_S_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= PPSC_S_UNPOWERED;
        else
            state_r <= state_nxt;
    end
    assign phy_state = state_r;

    // ==========================================================
    // Lane drive and termination
    logic gen3_drive;
    logic deepest_hp;
    assign gen3_drive = cfg.gen3_protocol && cfg.high_freq;
    assign deepest_hp = state_r == PPSC_S_OFF && cfg.hot_plug_enable;

    ppsc_ctl_s ctl_nxt;
    always_comb
    begin
        ctl_nxt = '0;
        ctl_nxt.clk_lane = `PPSC_TX_UNDEF;
        ctl_nxt.data_lane = `PPSC_TX_UNDEF;
        ctl_nxt.rx_term = `PPSC_RX_UNDEF;
        ctl_nxt.comp_enable = 1'b1;
        ctl_nxt.coding_8b10b = ac_mode && cfg.high_freq;
        ctl_nxt.scramble = cfg.high_freq && cfg.gen3_protocol;
        ctl_nxt.ctl_lines = (cfg.link_16bit && cfg.high_freq) ? 2'h2 : 2'h1;
        case (state_r)
            PPSC_S_UNPOWERED:
                ctl_nxt.rx_term = `PPSC_RX_OFF;
            PPSC_S_PWR_LOW:
            begin
                // Without support nothing is owed, so the lanes are left undefined
                if (HOT_PLUG_SUPPORTED || cfg.ac_supported)
                begin
                    ctl_nxt.clk_lane = `PPSC_TX_GND;
                    ctl_nxt.data_lane = `PPSC_TX_GND;
                end
            end
            PPSC_S_COLD:
            begin
                ctl_nxt.clk_lane = `PPSC_TX_DIFF;
                ctl_nxt.data_lane = `PPSC_TX_DIFF;
                ctl_nxt.rx_term = `PPSC_RX_DCDET;
                ctl_nxt.dll_on = 1'b1;
            end
            PPSC_S_AC_DETECT:
            begin
                ctl_nxt.clk_lane = `PPSC_TX_ACDET;
                ctl_nxt.data_lane = `PPSC_TX_ACDET;
                ctl_nxt.rx_term = `PPSC_RX_CTAP;
                ctl_nxt.dll_on = 1'b1;
            end
            PPSC_S_WARM:
            begin
                ctl_nxt.clk_lane = `PPSC_TX_DIFF;
                ctl_nxt.data_lane = ac_mode ? `PPSC_TX_IDLE : `PPSC_TX_DIFF;
                ctl_nxt.rx_term = ac_mode ? `PPSC_RX_CTAP : `PPSC_RX_DIFF;
                ctl_nxt.dll_on = 1'b1;
            end
            PPSC_S_ACTIVE:
            begin
                ctl_nxt.clk_lane = `PPSC_TX_DIFF;
                ctl_nxt.data_lane = `PPSC_TX_DIFF;
                ctl_nxt.rx_term = ac_mode ? `PPSC_RX_CTAP : `PPSC_RX_DIFF;
                ctl_nxt.dll_on = 1'b1;
                ctl_nxt.pr_on = 1'b1;
            end
            PPSC_S_DISC1, PPSC_S_DISC2:
            begin
                ctl_nxt.rx_term = ac_mode ? `PPSC_RX_CTAP : `PPSC_RX_DIFF;
                ctl_nxt.dll_on = 1'b1;
                ctl_nxt.pr_hold = 1'b1;
                ctl_nxt.dll_hold = state_r == PPSC_S_DISC2;
                ctl_nxt.clk_lane = (state_r == PPSC_S_DISC1) ? `PPSC_TX_DIFF : `PPSC_TX_IDLE;
                ctl_nxt.data_lane = `PPSC_TX_IDLE;
                if (!gen3_drive && !ac_mode)
                begin
                    ctl_nxt.clk_lane = (state_r == PPSC_S_DISC1) ? `PPSC_TX_DIFF : `PPSC_TX_HIZ;
                    ctl_nxt.data_lane = `PPSC_TX_HIZ;
                    if (!cfg.stop_tristate_enable)
                    begin
                        ctl_nxt.clk_lane = `PPSC_TX_DIFF;
                        ctl_nxt.data_lane = `PPSC_TX_DIFF;
                    end
                end
            end
            PPSC_S_OFF:
            begin
                ctl_nxt.comp_enable = 1'b0;
                if (deepest_hp)
                begin
                    ctl_nxt.clk_lane = `PPSC_TX_GND;
                    ctl_nxt.data_lane = `PPSC_TX_GND;
                    ctl_nxt.rx_term = `PPSC_RX_CTAP;
                end
                else
                begin
                    // High impedance saves power but is only legal on DC links
                    ctl_nxt.clk_lane = ac_mode ? `PPSC_TX_GND : `PPSC_TX_HIZ;
                    ctl_nxt.data_lane = ac_mode ? `PPSC_TX_GND : `PPSC_TX_HIZ;
                    ctl_nxt.rx_term = `PPSC_RX_OFF;
                end
            end
            default:
                ctl_nxt.rx_term = `PPSC_RX_OFF;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lane_ctl <= '0;
            lane_ctl.rx_term <= `PPSC_RX_OFF;
        end
        else
            lane_ctl <= ctl_nxt;
    end

    // ==========================================================
    // Coupling mode, learned on leaving cold reset
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            ac_mode <= 1'b0;
        else if (state_r == PPSC_S_PWR_LOW)
            ac_mode <= 1'b0;
        else if (state_r == PPSC_S_COLD && state_nxt == PPSC_S_AC_DETECT)
            ac_mode <= 1'b1;
    end

    // ==========================================================
    // DLL relock request
    logic was_deep_r;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            was_deep_r <= 1'b0;
        else if (state_r == PPSC_S_OFF)
            was_deep_r <= 1'b1;
        else if (state_r == PPSC_S_ACTIVE)
            was_deep_r <= 1'b0;
    end

    logic relock_cause;
    always_comb
    begin
        relock_cause = 1'b0;
        if (stop_release && width_increase &&
            (cfg.inactive_lane_state == `PPSC_INLN_RELOCK_A ||
             cfg.inactive_lane_state == `PPSC_INLN_RELOCK_B))
            relock_cause = 1'b1;
        if (was_deep_r && state_nxt == PPSC_S_ACTIVE && state_r != PPSC_S_ACTIVE)
            relock_cause = 1'b1;
        if (freq_change)
            relock_cause = 1'b1;
        if (state_r == PPSC_S_DISC2 && idle_timer_expired)
            relock_cause = 1'b1;
        if (state_r == PPSC_S_WARM && state_nxt != PPSC_S_WARM)
            relock_cause = 1'b1;
        if (RELOCK_EVERY_STOP && stop_release && cfg.hot_plug_enable &&
            cfg.power_state_select[1])
            relock_cause = 1'b1;
    end

    // Stretched so a slow DLL controller cannot miss a one-cycle cause
    logic [7:0] relock_cnt_r;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            relock_cnt_r <= 8'h00;
            dll_relock <= 1'b0;
        end
        else
        begin
            if (relock_cause)
                relock_cnt_r <= 8'(RELOCK_CYC);
            else if (relock_cnt_r != 8'h00)
                relock_cnt_r <= relock_cnt_r - 8'h01;
            dll_relock <= relock_cause || relock_cnt_r > 8'h01;
        end
    end
endmodule

// File: verification/ppsc_ctrl_checker.sv
// Concurrent checks on the ports of the PHY power-state controller.
// Assumes ppsc_pkg and ppsc_map.svh are compiled first; bound below.
`timescale 1ns/100ps
`include "ppsc_map.svh"
module ppsc_ctrl_checker #(
    parameter logic HOT_PLUG_SUPPORTED = 1'b1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic power_good,
    input wire ppsc_pkg::ppsc_cfg_s cfg,
    input wire ppsc_pkg::ppsc_ctl_s lane_ctl,
    input wire ppsc_pkg::ppsc_state_e phy_state,
    input wire logic dll_relock,
    input wire logic ac_mode
);
    import ppsc_pkg::*;
    // ==========
    // Assertions
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Two-cycle antecedents let the registered lane controls catch up
    pwr_low_a: assert property (!power_good [*4] |-> phy_state == PPSC_S_PWR_LOW)
        else $error("power good low did not force the low state");
    gnd_a: assert property ((phy_state == PPSC_S_PWR_LOW) [*2] |->
        lane_ctl.data_lane == `PPSC_TX_GND || !(HOT_PLUG_SUPPORTED || cfg.ac_supported))
        else $error("transmitters not grounded while power good low");
    cold_lanes_a: assert property ((phy_state == PPSC_S_COLD) [*2] |->
        lane_ctl.data_lane == `PPSC_TX_DIFF && lane_ctl.rx_term == `PPSC_RX_DCDET)
        else $error("cold reset lanes not in dc states");
    off_hotplug_a: assert property ((phy_state == PPSC_S_OFF && cfg.hot_plug_enable)
        [*2] |-> lane_ctl.data_lane == `PPSC_TX_GND && lane_ctl.rx_term == `PPSC_RX_CTAP
        && !lane_ctl.dll_on && !lane_ctl.comp_enable)
        else $error("phy off with hot plug lanes wrong");
    off_plain_a: assert property ((phy_state == PPSC_S_OFF && !cfg.hot_plug_enable)
        [*2] |-> lane_ctl.rx_term == `PPSC_RX_OFF && (lane_ctl.data_lane == `PPSC_TX_GND ||
        (lane_ctl.data_lane == `PPSC_TX_HIZ && !ac_mode)))
        else $error("phy off without hot plug lanes wrong");
    disc_drive_a: assert property ((phy_state == PPSC_S_DISC2 && !ac_mode &&
        !(cfg.gen3_protocol && cfg.high_freq)) [*2] |-> lane_ctl.data_lane ==
        (cfg.stop_tristate_enable ? `PPSC_TX_HIZ : `PPSC_TX_DIFF))
        else $error("first generation disconnect drive wrong");
    active_run_a: assert property ((phy_state == PPSC_S_ACTIVE) [*2] |-> lane_ctl.dll_on &&
        lane_ctl.pr_on && !lane_ctl.dll_hold && !lane_ctl.pr_hold)
        else $error("dll or phase recovery not running when active");
    disc1_hold_a: assert property ((phy_state == PPSC_S_DISC1) [*2] |-> lane_ctl.dll_on &&
        lane_ctl.pr_hold && lane_ctl.clk_lane == `PPSC_TX_DIFF)
        else $error("first disconnect level controls wrong");
    warm_relock_a: assert property ($fell(phy_state == PPSC_S_WARM) |-> ##[0:2] dll_relock)
        else $error("no relock on leaving warm reset");
    relock_len_a: assert property ($rose(dll_relock) |-> dll_relock [*8])
        else $error("relock request too short");
    // ==========
    // Coverage
    off_c: cover property ((phy_state == PPSC_S_OFF) [*2]);
    disc2_c: cover property (phy_state == PPSC_S_DISC2);
    relock_c: cover property ($rose(dll_relock));
endmodule

bind ppsc_ctrl ppsc_ctrl_checker #(.HOT_PLUG_SUPPORTED(HOT_PLUG_SUPPORTED)) ppsc_ctrl_checker_i (
    .core_clk, .resetn, .power_good, .cfg, .lane_ctl, .phy_state, .dll_relock, .ac_mode);

// File: verification/ppsc_link_partner.sv
// Far end of the link: link clock bursts and the coupling it presents.
// Assumes the bench raises start for each burst of n_edges rising edges.
`timescale 1ns/100ps
module ppsc_link_partner (
    input wire logic start,
    input wire logic [3:0] n_edges,
    input wire logic dc_coupled,
    output logic link_clk,
    output logic dc_seen
);
    // ==========
    // Clock stands low between bursts, as a powered-down partner's would
    initial link_clk = 1'b0;
    initial dc_seen = 1'b0;
    always @(posedge start)
    begin
        #3;
        repeat (n_edges)
        begin
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
    end
    // Detection settles slowly, so the core must not race it
    always @(dc_coupled) dc_seen <= #100 dc_coupled;
endmodule

// File: verification/ppsc_ctrl_tb_top.sv
// Self-checking bench for the PHY power-state controller.
// Assumes package, map header, checker and partner model compiled first.
`timescale 1ns/100ps
`include "ppsc_map.svh"
module ppsc_ctrl_tb_top;
    import ppsc_pkg::*;
    logic core_clk, resetn, power_good, link_stop_n, link_reset_n, link_clk, dc_seen;
    logic width_increase, freq_change, idle_timer_expired, dll_relock, link_clk_edge;
    logic ac_mode, start, dc_coupled;
    logic [3:0] n_edges;
    logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
    ppsc_phy_req_e phy_request;
    ppsc_cfg_s cfg;
    ppsc_ctl_s lane_ctl;
    ppsc_state_e phy_state;
    int errors = 0;
    int n_tests = 0;
    ppsc_ctrl ppsc_ctrl_i (.core_clk, .resetn, .power_good, .link_stop_n, .link_reset_n,
        .link_clk, .phy_request, .dc_coupling_detected(dc_seen), .cfg, .width_increase,
        .freq_change, .idle_timer_expired, .lane_ctl, .phy_state, .dll_relock,
        .link_clk_edge, .ac_mode);
    ppsc_link_partner ppsc_link_partner_i (.start, .n_edges, .dc_coupled, .link_clk, .dc_seen);
    // ==========
    // Clock and helpers
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wait_st(input ppsc_state_e st);
        for (int i = 0; i < 30 && phy_state !== st; i++) tick(1);
        chk(phy_state === st, st.name());
        tick(2);
    endtask
    // Counts the relock pulse; zero expected means none may appear
    task automatic relock(input int exp);
        int n;
        n = 0;
        for (int i = 0; i < 10 && dll_relock !== 1'b1; i++) tick(1);
        for (int i = 0; i < 30 && dll_relock === 1'b1; i++)
        begin
            n++;
            tick(1);
        end
        chk(n == exp, "relock pulse length");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        chk(phy_state === PPSC_S_UNPOWERED && lane_ctl.rx_term === `PPSC_RX_OFF, "reset state");
        chk(dll_relock === 1'b0 && ac_mode === 1'b0, "reset outputs");
        resetn = 1'b1;
        wait_st(PPSC_S_PWR_LOW);
        chk(lane_ctl.data_lane === `PPSC_TX_GND, "grounded tx");
        $display("test reset done");
    endtask
    task automatic t_cold;
        power_good = 1'b1;
        // Coding is on only with AC coupling at the high rate
        cfg.high_freq = 1'b1;
        wait_st(PPSC_S_AC_DETECT);
        chk(lane_ctl.data_lane === `PPSC_TX_ACDET && lane_ctl.rx_term === `PPSC_RX_CTAP, "ac");
        chk(ac_mode === 1'b1 && lane_ctl.coding_8b10b === 1'b1, "ac coding");
        resetn = 1'b0;
        dc_coupled = 1'b1;
        tick(20);
        resetn = 1'b1;
        wait_st(PPSC_S_COLD);
        chk(lane_ctl.data_lane === `PPSC_TX_DIFF && lane_ctl.rx_term === `PPSC_RX_DCDET, "dc");
        $display("test cold done");
    endtask
    task automatic t_active;
        cfg.gen3_protocol = 1'b1;
        cfg.high_freq = 1'b1;
        cfg.link_16bit = 1'b1;
        link_reset_n = 1'b1;
        wait_st(PPSC_S_WARM);
        phy_request = PPSC_PH_ACTIVE;
        relock(`PPSC_RELOCK_CYC);
        chk(lane_ctl.dll_on === 1'b1 && lane_ctl.pr_on === 1'b1, "active dll");
        chk(lane_ctl.scramble === 1'b1 && lane_ctl.coding_8b10b === 1'b0, "dc coding");
        chk(lane_ctl.ctl_lines === 2'h2, "two ctl lines");
        cfg.high_freq = 1'b0;
        tick(3);
        chk(lane_ctl.scramble === 1'b0 && lane_ctl.ctl_lines === 2'h1, "low rate");
        freq_change = 1'b1;
        tick(1);
        freq_change = 1'b0;
        relock(`PPSC_RELOCK_CYC);
        $display("test active done");
    endtask
    task automatic t_disc;
        cfg.gen3_protocol = 1'b0;
        phy_request = PPSC_PH_DISC;
        link_stop_n = 1'b0;
        tick(8);
        chk(phy_state === PPSC_S_ACTIVE && lane_ctl.pr_on === 1'b1, "active hold");
        link_stop_n = 1'b1;
        tick(6);
        cfg.power_state_select = 2'h1;
        link_stop_n = 1'b0;
        wait_st(PPSC_S_DISC1);
        chk(lane_ctl.data_lane === `PPSC_TX_DIFF && lane_ctl.pr_hold === 1'b1, "ls1");
        link_stop_n = 1'b1;
        wait_st(PPSC_S_ACTIVE);
        cfg.stop_tristate_enable = 1'b1;
        cfg.power_state_select = 2'h2;
        foreach (codes[k])
        begin
            cfg.inactive_lane_state = codes[k];
            link_stop_n = 1'b0;
            wait_st(PPSC_S_DISC2);
            chk(lane_ctl.data_lane === `PPSC_TX_HIZ && lane_ctl.dll_hold === 1'b1, "ls2");
            if (k == 0)
            begin
                idle_timer_expired = 1'b1;
                tick(1);
                idle_timer_expired = 1'b0;
                relock(`PPSC_RELOCK_CYC);
            end
            // Width grows across the stop release, which triggers relock for lane states 01 and 11
            width_increase = 1'b1;
            link_stop_n = 1'b1;
            relock(k == 0 ? 0 : `PPSC_RELOCK_CYC);
            width_increase = 1'b0;
            wait_st(PPSC_S_ACTIVE);
        end
        $display("test disconnect done");
    endtask
    task automatic t_off;
        cfg.hot_plug_enable = 1'b1;
        phy_request = PPSC_PH_OFF;
        wait_st(PPSC_S_OFF);
        chk(lane_ctl.data_lane === `PPSC_TX_GND && lane_ctl.rx_term === `PPSC_RX_CTAP, "off");
        chk(lane_ctl.comp_enable === 1'b0 && lane_ctl.dll_on === 1'b0, "off dll");
        cfg.hot_plug_enable = 1'b0;
        tick(3);
        chk(lane_ctl.rx_term === `PPSC_RX_OFF, "rx amp off");
        chk(lane_ctl.data_lane === `PPSC_TX_HIZ || lane_ctl.data_lane === `PPSC_TX_GND, "tx");
        $display("test off done");
    endtask
    task automatic t_link_clk;
        int n;
        n = 0;
        n_edges = 4'h5;
        start = 1'b1;
        repeat (70)
        begin
            if (link_clk_edge === 1'b1)
                n++;
            tick(1);
        end
        start = 1'b0;
        chk(n == 5, "link clock edges");
        $display("test link clock done");
    endtask
    // ==========
    // Main sequence and watchdog
    initial
    begin
        {resetn, power_good, link_stop_n, link_reset_n, start, dc_coupled} = 6'h08;
        {width_increase, freq_change, idle_timer_expired} = 3'h0;
        n_edges = 4'h0;
        // Park in warm reset until the active test asks for more
        phy_request = PPSC_PH_WARM;
        cfg = '0;
        cfg.ac_supported = 1'b1;
        tick(12);
        t_reset;
        t_cold;
        t_active;
        t_disc;
        t_off;
        t_link_clk;
        report_and_stop;
    end
    initial
    begin
        #50000;
        errors++;
        report_and_stop;
    end
endmodule
